/* src/pdclr_regs.sv */
`timescale 1ns/1ps
module pdclr_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Completed serial write word
	input wire pdclr_pkg::pdclr_wr_t wr,
	// Readback
	output logic [31:0] readback_data,
	// Synthesizer controls
	output pdclr_pkg::pdclr_pll_t pll,
	output logic write_protect_bit
);
	typedef struct packed {
		logic [31:0] cal_div;
		logic [31:0] fb_div;
		logic [31:0] rb_prot;
		pdclr_pkg::pdclr_state_t state;
		logic [15:0] cal_cnt;
		logic sync;
		logic [4:0] rb_sel_d;
		logic [15:0] cal_len;
	} pdclr_st_t;
	pdclr_st_t st_reg;
	pdclr_st_t st_next;
	logic accept;
	logic start_cal;
	logic [31:0] mem_rdata;
	logic [4:0] rb_sel;
	logic rb_reserved;
	logic [2:0] pre_code;

	////////////////////////////////////////////////////////////////////////////////
	// Write acceptance and storage
	assign rb_sel = st_reg.rb_prot[pdclr_pkg::RB_HI:pdclr_pkg::RB_LO];
	always_comb
	begin
		accept = 1'b0;
		if (wr.valid)
		begin
			if (wr.addr == pdclr_pkg::ADDR_RB_PROT)
				accept = 1'b1;
			else
				accept = !st_reg.rb_prot[pdclr_pkg::PROT_BIT];
		end
	end
	assign start_cal = accept && (wr.addr == pdclr_pkg::ADDR_FB_DIV);

	pdclr_regmem u_mem (
		.clock(clock),
		.sys_rst(sys_rst),
		.we(accept),
		.waddr(wr.addr),
		.wdata(wr.data),
		.raddr(rb_sel),
		.rdata(mem_rdata)
	);

	always_comb
	begin
		st_next = st_reg;
		st_next.sync = 1'b0;
		st_next.rb_sel_d = rb_sel;
		if (accept && wr.addr == pdclr_pkg::ADDR_CAL_DIV)
			st_next.cal_div = wr.data;
		if (accept && wr.addr == pdclr_pkg::ADDR_FB_DIV)
			st_next.fb_div = wr.data;
		if (accept && wr.addr == pdclr_pkg::ADDR_RB_PROT)
			st_next.rb_prot = wr.data;
		case (st_reg.state)
			pdclr_pkg::PDCLR_IDLE:
			begin
				if (start_cal)
				begin
					st_next.state = pdclr_pkg::PDCLR_CAL;
					st_next.cal_cnt = 16'(pdclr_pkg::CAL_CYCLES - 1);
					st_next.sync = 1'b1;
				end
			end
			pdclr_pkg::PDCLR_CAL:
			begin
				if (start_cal)
				begin
					st_next.cal_cnt = 16'(pdclr_pkg::CAL_CYCLES - 1);
					st_next.sync = 1'b1;
				end
				else if (st_reg.cal_cnt == 16'h0000)
					st_next.state = pdclr_pkg::PDCLR_IDLE;
				else
					st_next.cal_cnt = st_reg.cal_cnt - 16'h0001;
			end
			default:
				st_next.state = pdclr_pkg::PDCLR_IDLE;
		endcase
		// Cycles spent in the current run, read by the duration checks
		if (st_reg.state == pdclr_pkg::PDCLR_CAL && st_next.state == pdclr_pkg::PDCLR_CAL && !start_cal)
			st_next.cal_len = st_reg.cal_len + 16'h0001;
		else
			st_next.cal_len = 16'h0000;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.cal_div <= pdclr_pkg::CAL_DIV_RST;
			st_reg.fb_div <= pdclr_pkg::FB_DIV_RST;
			st_reg.rb_prot <= pdclr_pkg::RB_PROT_RST;
			st_reg.state <= pdclr_pkg::PDCLR_IDLE;
		end
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Readback and synthesizer outputs
	always_comb
	begin
		case (st_reg.rb_sel_d)
			5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h19, 5'h1b:
				rb_reserved = 1'b1;
			default:
				rb_reserved = 1'b0;
		endcase
	end
	assign readback_data = rb_reserved ? 32'h0000_0000 : mem_rdata;

	assign pre_code = st_reg.fb_div[pdclr_pkg::PRE_HI:pdclr_pkg::PRE_LO];
	always_comb
	begin
		pll.prescale = {1'b0, pre_code};
		if (pre_code == 3'h0)
			pll.prescale = pdclr_pkg::PRE_DIV_ZERO;
		else if (pre_code == 3'h1 || pre_code == 3'h2)
			pll.prescale = pdclr_pkg::PRE_DIV_LOW;
		pll.calibrating = (st_reg.state == pdclr_pkg::PDCLR_CAL);
		if (pll.calibrating)
			pll.fb_div = st_reg.cal_div[pdclr_pkg::DIV_HI:pdclr_pkg::DIV_LO];
		else
			pll.fb_div = st_reg.fb_div[pdclr_pkg::DIV_HI:pdclr_pkg::DIV_LO];
		pll.ref_freq_range = st_reg.cal_div[pdclr_pkg::FREQ_HI:pdclr_pkg::FREQ_LO];
		pll.sync_pulse = st_reg.sync;
	end
	assign write_protect_bit = st_reg.rb_prot[pdclr_pkg::PROT_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_fb_start_cal: assert property (@(posedge clock) disable iff (sys_rst)
		wr.valid && wr.addr == pdclr_pkg::ADDR_FB_DIV && !write_protect_bit |=> pll.calibrating && pll.sync_pulse)
		else $error("register 30 write did not start calibration");
	chk_other_no_cal: assert property (@(posedge clock) disable iff (sys_rst)
		!pll.calibrating && !(wr.valid && wr.addr == pdclr_pkg::ADDR_FB_DIV) |=> !pll.calibrating)
		else $error("calibration started without register 30 write");
	chk_sync_with_cal: assert property (@(posedge clock) disable iff (sys_rst)
		pll.sync_pulse |-> pll.calibrating ##1 (!pll.sync_pulse || $past(start_cal)))
		else $error("sync pulse outside calibration start");
	chk_cal_div_used: assert property (@(posedge clock) disable iff (sys_rst)
		pll.calibrating |-> pll.fb_div == st_reg.cal_div[pdclr_pkg::DIV_HI:pdclr_pkg::DIV_LO])
		else $error("calibration divide not used");
	chk_prescale_map: assert property (@(posedge clock) disable iff (sys_rst)
		pll.prescale != 4'h0 && pll.prescale != 4'h1 && (pre_code != 3'h0 || pll.prescale == 4'h8))
		else $error("bad prescaler divide");
	chk_normal_div: assert property (@(posedge clock) disable iff (sys_rst)
		!pll.calibrating |-> pll.fb_div == st_reg.fb_div[pdclr_pkg::DIV_HI:pdclr_pkg::DIV_LO])
		else $error("normal divide not used");
	chk_protect_hold: assert property (@(posedge clock) disable iff (sys_rst)
		write_protect_bit && wr.valid && wr.addr == pdclr_pkg::ADDR_FB_DIV |=> $stable(st_reg.fb_div) && !pll.sync_pulse)
		else $error("protected register changed");
	chk_protect_reg_open: assert property (@(posedge clock) disable iff (sys_rst)
		wr.valid && wr.addr == pdclr_pkg::ADDR_RB_PROT |=> write_protect_bit == $past(wr.data[pdclr_pkg::PROT_BIT]))
		else $error("register 31 write refused");
	chk_rb_reserved: assert property (@(posedge clock) disable iff (sys_rst)
		rb_reserved |-> readback_data == 32'h0000_0000)
		else $error("reserved readback not zero");

	// Run length, restart, sync, prescaler, protection and readback paths
	chk_cal_len_max: assert property (@(posedge clock) disable iff (sys_rst)
		pll.calibrating |-> st_reg.cal_len < 16'(pdclr_pkg::CAL_CYCLES))
		else $error("calibration run too long");
	chk_cal_len_full: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(pll.calibrating) |-> $past(st_reg.cal_len) == 16'(pdclr_pkg::CAL_CYCLES - 1))
		else $error("calibration run ended early");
	chk_cal_restart: assert property (@(posedge clock) disable iff (sys_rst)
		pll.calibrating && start_cal |=> pll.calibrating && pll.sync_pulse && st_reg.cal_len == 16'h0000)
		else $error("register 30 write did not restart calibration");
	chk_other_no_sync: assert property (@(posedge clock) disable iff (sys_rst)
		wr.valid && wr.addr != pdclr_pkg::ADDR_FB_DIV |=> !pll.sync_pulse)
		else $error("sync after write to another register");
	chk_cal_div_hold: assert property (@(posedge clock) disable iff (sys_rst)
		pll.calibrating && !(accept && wr.addr == pdclr_pkg::ADDR_CAL_DIV)
		|=> !pll.calibrating || $stable(pll.fb_div))
		else $error("divide moved during calibration");
	chk_sync_cause: assert property (@(posedge clock) disable iff (sys_rst)
		pll.sync_pulse |-> $past(start_cal))
		else $error("sync pulse without calibration start");
	chk_idle_no_sync: assert property (@(posedge clock) disable iff (sys_rst)
		!pll.calibrating |-> !pll.sync_pulse)
		else $error("sync pulse while idle");
	chk_prescale_code: assert property (@(posedge clock) disable iff (sys_rst)
		pre_code > 3'h2 |-> pll.prescale == {1'b0, pre_code})
		else $error("prescaler does not follow its code");
	chk_prescale_low: assert property (@(posedge clock) disable iff (sys_rst)
		pre_code == 3'h1 || pre_code == 3'h2 |-> pll.prescale == pdclr_pkg::PRE_DIV_LOW)
		else $error("low prescaler code not divide by two");
	chk_protect_all: assert property (@(posedge clock) disable iff (sys_rst)
		write_protect_bit && wr.valid && wr.addr != pdclr_pkg::ADDR_RB_PROT
		|=> $stable(st_reg.cal_div) && $stable(st_reg.fb_div) && $stable(st_reg.rb_prot))
		else $error("protected register written");
	chk_wp_hold: assert property (@(posedge clock) disable iff (sys_rst)
		!(wr.valid && wr.addr == pdclr_pkg::ADDR_RB_PROT) |=> $stable(write_protect_bit))
		else $error("protection changed without register 31 write");
	chk_rb_sel_open: assert property (@(posedge clock) disable iff (sys_rst)
		wr.valid && wr.addr == pdclr_pkg::ADDR_RB_PROT
		|=> rb_sel == $past(wr.data[pdclr_pkg::RB_HI:pdclr_pkg::RB_LO]))
		else $error("readback selection refused");
	chk_rb_fb_data: assert property (@(posedge clock) disable iff (sys_rst)
		rb_sel == pdclr_pkg::ADDR_FB_DIV |=> readback_data == $past(st_reg.fb_div))
		else $error("register 30 readback wrong");
	chk_rb_cal_data: assert property (@(posedge clock) disable iff (sys_rst)
		rb_sel == pdclr_pkg::ADDR_CAL_DIV |=> readback_data == $past(st_reg.cal_div))
		else $error("register 29 readback wrong");
	chk_rb_quiet: assert property (@(posedge clock) disable iff (sys_rst)
		!wr.valid |=> $stable(st_reg.cal_div) && $stable(st_reg.fb_div) && $stable(st_reg.rb_prot))
		else $error("register changed without a write");
endmodule : pdclr_regs

/* src/pdclr_pkg.sv */
package pdclr_pkg;
	localparam logic [4:0] ADDR_CAL_DIV = 5'h1d;
	localparam logic [4:0] ADDR_FB_DIV = 5'h1e;
	localparam logic [4:0] ADDR_RB_PROT = 5'h1f;
	localparam int DIV_LO = 5;
	localparam int DIV_HI = 22;
	localparam int PRE_LO = 24;
	localparam int PRE_HI = 26;
	localparam int FREQ_LO = 24;
	localparam int FREQ_HI = 26;
	localparam int RB_LO = 16;
	localparam int RB_HI = 20;
	localparam int PROT_BIT = 5;
	localparam logic [31:0] CAL_DIV_RST = 32'h0000_0000;
	localparam logic [31:0] FB_DIV_RST = 32'h0000_0000;
	localparam logic [31:0] RB_PROT_RST = 32'h0000_0000;
	localparam logic [3:0] PRE_DIV_ZERO = 4'h8;
	localparam logic [3:0] PRE_DIV_LOW = 4'h2;
	// Calibration run length in ns, and its cycle count at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int CAL_TIME_NS = 1000;
	localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_REGS = 32;
	typedef enum logic [0:0] {PDCLR_IDLE, PDCLR_CAL} pdclr_state_t;
	typedef struct packed {
		logic valid;
		logic [4:0] addr;
		logic [31:0] data;
	} pdclr_wr_t;
	typedef struct packed {
		logic [3:0] prescale;
		logic [17:0] fb_div;
		logic [2:0] ref_freq_range;
		logic calibrating;
		logic sync_pulse;
	} pdclr_pll_t;
endpackage : pdclr_pkg

/* src/pdclr_regmem.sv */
`timescale 1ns/1ps
module pdclr_regmem (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Write side
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [31:0] wdata,
	// Read side
	input wire logic [4:0] raddr,
	output logic [31:0] rdata
);
	typedef struct packed {
		logic [pdclr_pkg::NUM_REGS-1:0][31:0] mem;
		logic [31:0] rdata;
	} pdclr_mem_st_t;
	pdclr_mem_st_t st_reg;
	pdclr_mem_st_t st_next;
	always_comb
	begin
		st_next = st_reg;
		if (we)
			st_next.mem[waddr] = wdata;
		st_next.rdata = st_reg.mem[raddr];
	end
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign rdata = st_reg.rdata;
endmodule : pdclr_regmem

/* verif/pdclr_host.sv */
`timescale 1ns/1ps
module pdclr_host (
	// Clock
	input wire logic clock,
	// Completed words to the device
	output pdclr_pkg::pdclr_wr_t wr
);
	initial wr = '0;
	// One word a call; the bus shows inverted junk once released
	task automatic send(input logic [4:0] a, input logic [31:0] d);
	begin
		@(posedge clock);
		wr <= '{valid: 1'b1, addr: a, data: d};
		@(posedge clock);
		wr <= '{valid: 1'b0, addr: ~a, data: ~d};
	end
	endtask : send
	// Range code goes in before any calibration, divide never zero
	task automatic setup(input logic [2:0] rng, input logic [17:0] cal);
	begin
		send(pdclr_pkg::ADDR_CAL_DIV, {5'h0, rng, 1'b0, (cal == 18'h0) ? 18'h1 : cal, 5'h0});
	end
	endtask : setup
endmodule : pdclr_host

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	pdclr_pkg::pdclr_wr_t wr;
	logic [31:0] readback_data;
	pdclr_pkg::pdclr_pll_t pll;
	logic write_protect_bit;
	int fail_count = 0;
	int checks = 0;
	logic [17:0] cal;
	logic [17:0] n;
	logic [2:0] rng;
	always #5 clock = ~clock;
	pdclr_host host_u (.clock(clock), .wr(wr));
	pdclr_regs dut_u (.clock(clock), .sys_rst(sys_rst), .wr(wr), .readback_data(readback_data), .pll(pll),
		.write_protect_bit(write_protect_bit));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] word(input logic [2:0] p, input logic [17:0] v);
		return {5'h0, p, 1'b0, v, 5'h0};
	endfunction : word
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	begin
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	end
	endtask : chk
	task automatic results;
	begin
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask : results
	task automatic fb_write(input logic [2:0] p, input logic [17:0] v, input logic run);
	begin
		host_u.send(pdclr_pkg::ADDR_FB_DIV, word(p, v));
		#1;
		chk("calibrating", 32'(run), 32'(pll.calibrating));
		chk("sync", 32'(run), 32'(pll.sync_pulse));
		if (run)
		begin
			chk("fb_cal", 32'(cal), 32'(pll.fb_div));
			@(posedge clock);
			#1;
			chk("sync_end", 32'h0, 32'(pll.sync_pulse));
			repeat (pdclr_pkg::CAL_CYCLES - 2) @(posedge clock);
			#1;
			chk("cal_last", 32'h1, 32'(pll.calibrating));
			@(posedge clock);
			#1;
			chk("cal_done", 32'h0, 32'(pll.calibrating));
			chk("fb_div", 32'(v), 32'(pll.fb_div));
			chk("prescale", (p == 3'h0) ? 32'h8 : (p < 3'h3) ? 32'h2 : 32'(p), 32'(pll.prescale));
		end
	end
	endtask : fb_write
	task automatic rb(input logic [4:0] sel, input logic wp, input logic [31:0] e);
	begin
		host_u.send(pdclr_pkg::ADDR_RB_PROT, {11'h0, sel, 10'h0, wp, 5'h0});
		repeat (3) @(posedge clock);
		#1;
		chk("readback", e, readback_data);
		chk("protect", 32'(wp), 32'(write_protect_bit));
	end
	endtask : rb
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hbcd2));
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1;
		chk("rst_prescale", 32'h8, 32'(pll.prescale));
		chk("rst_cal", 32'h0, 32'(pll.calibrating));
		chk("rst_protect", 32'h0, 32'(write_protect_bit));
		for (int i = 0; i < 8; i++)
		begin
			rng = 3'($urandom_range(0, 2));
			cal = (i == 7) ? 18'h3ffff : 18'($urandom_range(1, 32'h3ffff));
			n = (i == 7) ? 18'h1 : 18'($urandom_range(1, 32'h3ffff));
			host_u.setup(rng, cal);
			#1;
			chk("no_cal", 32'h0, 32'(pll.calibrating));
			chk("range", 32'(rng), 32'(pll.ref_freq_range));
			fb_write(3'(i), n, 1'b1);
		end
		rb(5'd29, 1'b0, word(rng, cal) | {5'h0, rng, 24'h0});
		rb(5'd15, 1'b0, 32'h0);
		rb(5'd30, 1'b1, word(3'h7, 18'h1));
		fb_write(3'h3, 18'h5, 1'b0);
		host_u.setup(3'h1, 18'h2);
		rb(5'd29, 1'b1, word(rng, cal));
		rb(5'd30, 1'b1, word(3'h7, 18'h1));
		rb(5'd30, 1'b0, word(3'h7, 18'h1));
		fb_write(3'h3, 18'h5, 1'b1);
		host_u.send(pdclr_pkg::ADDR_FB_DIV, word(3'h4, 18'h9));
		fb_write(3'h5, 18'h6, 1'b1);
		results();
	end
	initial
	begin
		#50000;
		fail_count++;
		results();
	end
endmodule : tb_top
